// *** hw/pcs_host.sv ***
// host end: AXI4-Lite controlled two-wire bus master plus strap drivers
`timescale 1ns/1ps
`default_nettype none
module pcs_host (
	input wire logic clk_sys,
	input wire logic nrst,
	pcs_link_if.host link,
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq
);
	import pcs_pkg::*;
	// ==========================================================
	// register slave
	logic [4:0] ctrl_reg;
	logic [7:0] wdata_reg, rdata_reg;
	logic [st_width-1:0] status_reg, mask_reg, ev_set;
	logic [6:0] strap_reg;
	logic aw_hold, w_hold, go_reg, busy;
	logic [5:0] aw_q;
	logic [31:0] w_q;
	wire wr_do = aw_hold && w_hold && !s_axi_bvalid;
	wire rd_do = s_axi_arvalid && !s_axi_rvalid;
	wire rd_status = rd_do && s_axi_araddr == reg_status;
	logic [31:0] rd_mux;
	assign s_axi_awready = !aw_hold;
	assign s_axi_wready = !w_hold;
	assign s_axi_arready = !s_axi_rvalid;
	always_comb begin
		rd_mux = 32'h0;
		if (s_axi_araddr == reg_ctrl) rd_mux = {26'h0, busy, ctrl_reg};
		else if (s_axi_araddr == reg_wdata) rd_mux = {24'h0, wdata_reg};
		else if (s_axi_araddr == reg_rdata) rd_mux = {24'h0, rdata_reg};
		else if (s_axi_araddr == reg_status) rd_mux = {30'h0, status_reg};
		else if (s_axi_araddr == reg_mask) rd_mux = {30'h0, mask_reg};
		else if (s_axi_araddr == reg_strap) rd_mux = {25'h0, strap_reg};
	end
	wire bad_rd = !(s_axi_araddr inside {reg_ctrl, reg_wdata, reg_rdata, reg_status,
		reg_mask, reg_strap});
	wire bad_wr = !(aw_q inside {reg_ctrl, reg_wdata, reg_mask, reg_strap});
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_q <= 6'h00;
			w_q <= 32'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
			ctrl_reg <= 5'h00;
			wdata_reg <= 8'h00;
			mask_reg <= '0;
			strap_reg <= 7'h00;
			status_reg <= '0;
			go_reg <= 1'b0;
		end else begin
			go_reg <= 1'b0;
			if (s_axi_awvalid && !aw_hold) begin
				aw_hold <= 1'b1;
				aw_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_hold) begin
				w_hold <= 1'b1;
				w_q <= s_axi_wdata;
			end
			if (wr_do) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= bad_wr ? 2'h2 : 2'h0;
				if (aw_q == reg_ctrl && !busy) begin
					ctrl_reg <= w_q[4:0];
					go_reg <= 1'b1;
				end else if (aw_q == reg_wdata) wdata_reg <= w_q[7:0];
				else if (aw_q == reg_mask) mask_reg <= w_q[st_width-1:0];
				else if (aw_q == reg_strap) strap_reg <= w_q[6:0];
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (rd_do) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= bad_rd ? 2'h2 : 2'h0;
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			// set wins over the read clear
			status_reg <= (rd_status ? '0 : status_reg) | ev_set;
		end
	end
	assign irq = |(status_reg & mask_reg);
	// ==========================================================
	// bit engine: one byte (or start/stop) per ctrl write
	pcs_host_state_t st_reg;
	logic [7:0] sh_reg;
	logic [3:0] bit_reg;
	logic [7:0] tmr_reg;
	logic [1:0] ph_reg;
	logic scl_lo, sda_lo, nack_seen;
	logic [1:0] sda_s;
	wire tick = tmr_reg == 8'(scl_half_cyc - 1);
	assign busy = st_reg != pcs_h_idle;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_reg <= pcs_h_idle;
			sh_reg <= 8'h00;
			bit_reg <= 4'h0;
			tmr_reg <= 8'h00;
			ph_reg <= 2'h0;
			scl_lo <= 1'b0;
			sda_lo <= 1'b0;
			rdata_reg <= 8'h00;
			ev_set <= '0;
			nack_seen <= 1'b0;
			sda_s <= 2'h3;
		end else begin
			sda_s <= {sda_s[0], link.sda};
			ev_set <= '0;
			tmr_reg <= tick ? 8'h00 : tmr_reg + 8'h01;
			case (st_reg)
				pcs_h_idle: begin
					tmr_reg <= 8'h00;
					ph_reg <= 2'h0;
					bit_reg <= 4'h0;
					if (go_reg) begin
						sh_reg <= ctrl_reg[ctrl_read_bit] ? 8'hff : wdata_reg;
						if (ctrl_reg[ctrl_start_bit]) st_reg <= pcs_h_start;
						else if (ctrl_reg[ctrl_write_bit] || ctrl_reg[ctrl_read_bit])
							st_reg <= pcs_h_bit;
						else if (ctrl_reg[ctrl_stop_bit]) st_reg <= pcs_h_stop;
						else st_reg <= pcs_h_done;
					end
				end
				pcs_h_start: if (tick) begin
					ph_reg <= ph_reg + 2'h1;
					if (ph_reg == 2'h0) begin
						scl_lo <= 1'b0;
						sda_lo <= 1'b0;
					end else if (ph_reg == 2'h1) sda_lo <= 1'b1; // start: sda falls, scl high
					else begin
						scl_lo <= 1'b1;
						ph_reg <= 2'h0;
						st_reg <= (ctrl_reg[ctrl_write_bit] || ctrl_reg[ctrl_read_bit])
							? pcs_h_bit : pcs_h_done;
					end
				end
				pcs_h_bit, pcs_h_ack: if (tick) begin
					ph_reg <= ph_reg + 2'h1;
					if (ph_reg == 2'h0) begin
						scl_lo <= 1'b1;
						if (st_reg == pcs_h_bit) sda_lo <= !sh_reg[7]; // msb first
						else sda_lo <= !ctrl_reg[ctrl_read_bit] ? 1'b0
							: !ctrl_reg[ctrl_nack_bit];
					end else if (ph_reg == 2'h1) scl_lo <= 1'b0;
					else if (ph_reg == 2'h2) begin
						if (st_reg == pcs_h_bit) sh_reg <= {sh_reg[6:0], sda_s[1]};
						else nack_seen <= sda_s[1];
					end else begin
						scl_lo <= 1'b1;
						ph_reg <= 2'h0;
						if (st_reg == pcs_h_ack) begin
							sda_lo <= 1'b0;
							st_reg <= ctrl_reg[ctrl_stop_bit] ? pcs_h_stop : pcs_h_done;
						end else if (bit_reg == 4'd7) begin
							sda_lo <= 1'b0;
							st_reg <= pcs_h_ack;
						end
						bit_reg <= bit_reg + 4'd1;
					end
				end
				pcs_h_stop: if (tick) begin
					ph_reg <= ph_reg + 2'h1;
					if (ph_reg == 2'h0) begin
						sda_lo <= 1'b1;
						scl_lo <= 1'b1;
					end else if (ph_reg == 2'h1) scl_lo <= 1'b0;
					else begin
						sda_lo <= 1'b0;
						st_reg <= pcs_h_done;
					end
				end
				pcs_h_done: begin
					if (ctrl_reg[ctrl_read_bit]) rdata_reg <= sh_reg;
					ev_set[st_done_bit] <= 1'b1;
					ev_set[st_nack_bit] <= ctrl_reg[ctrl_write_bit] && nack_seen;
					nack_seen <= 1'b0;
					st_reg <= pcs_h_idle;
				end
				default: st_reg <= pcs_h_idle;
			endcase
		end
	end
	assign link.scl_o = 1'b0;
	assign link.scl_oe = scl_lo;
	assign link.sda_h_o = 1'b0;
	assign link.sda_h_oe = sda_lo;
	assign link.comm_or_limit_strap_pin = strap_reg[0];
	assign link.fault_latch_select_pin = strap_reg[1];
	assign link.attach_detect_select_pin = strap_reg[2];
	assign link.port_power_enable_pin = strap_reg[3];
	assign link.emulation_enable_pin = strap_reg[4];
	assign link.profile_select_low_pin = strap_reg[5];
	assign link.profile_select_high_pin = strap_reg[6];
endmodule // pcs_host
`default_nettype wire

// *** shared/pcs_pkg.sv ***
// shared constants and types for the port controller serial client
`default_nettype none
package pcs_pkg;
	localparam int unsigned clk_hz = 20000000;
	localparam int unsigned scl_khz = 100;
	// quarter period of the host serial clock in system cycles (one bit phase)
	localparam int unsigned scl_half_cyc = clk_hz / (scl_khz * 1000 * 2);
	localparam logic [6:0] client_addr_def = 7'h33;
	localparam logic [7:0] ptr_reset = 8'h00;
	localparam logic [7:0] ptr_wrap_step = 8'h01;
	localparam int unsigned byte_bits = 8;
	// host register offsets (AXI4-Lite, byte addresses)
	localparam logic [5:0] reg_ctrl = 6'h00;
	localparam logic [5:0] reg_wdata = 6'h04;
	localparam logic [5:0] reg_rdata = 6'h08;
	localparam logic [5:0] reg_status = 6'h0c;
	localparam logic [5:0] reg_mask = 6'h10;
	localparam logic [5:0] reg_strap = 6'h14;
	// ctrl fields
	localparam int unsigned ctrl_start_bit = 0;
	localparam int unsigned ctrl_stop_bit = 1;
	localparam int unsigned ctrl_write_bit = 2;
	localparam int unsigned ctrl_read_bit = 3;
	localparam int unsigned ctrl_nack_bit = 4;
	// status event bits
	localparam int unsigned st_done_bit = 0;
	localparam int unsigned st_nack_bit = 1;
	localparam int unsigned st_width = 2;
	typedef enum logic [5:0] {
		pcs_h_idle = 6'b000001,
		pcs_h_start = 6'b000010,
		pcs_h_bit = 6'b000100,
		pcs_h_ack = 6'b001000,
		pcs_h_stop = 6'b010000,
		pcs_h_done = 6'b100000
	} pcs_host_state_t;
	typedef enum logic [4:0] {
		pcs_c_idle = 5'b00001,
		pcs_c_addr = 5'b00010,
		pcs_c_rx = 5'b00100,
		pcs_c_tx = 5'b01000,
		pcs_c_ack = 5'b10000
	} pcs_client_state_t;
endpackage
`default_nettype wire

// *** shared/pcs_link_if.sv ***
// two-wire link plus stand-alone strap pins between host and client
`timescale 1ns/1ps
`default_nettype none
interface pcs_link_if;
	logic scl_o;
	logic scl_oe;
	logic sda_h_o;
	logic sda_h_oe;
	logic sda_c_o;
	logic sda_c_oe;
	logic scl;
	logic sda;
	logic comm_or_limit_strap_pin;
	logic fault_latch_select_pin;
	logic attach_detect_select_pin;
	logic port_power_enable_pin;
	logic emulation_enable_pin;
	logic profile_select_low_pin;
	logic profile_select_high_pin;
	logic alert_pin_n;
	logic attach_detected_pin_n;
	// open-drain wired-and with pull-ups
	assign scl = !(scl_oe && !scl_o);
	assign sda = !(sda_h_oe && !sda_h_o) && !(sda_c_oe && !sda_c_o);
	modport host (output scl_o, scl_oe, sda_h_o, sda_h_oe, input scl, sda,
		output comm_or_limit_strap_pin, fault_latch_select_pin, attach_detect_select_pin,
		port_power_enable_pin, emulation_enable_pin, profile_select_low_pin,
		profile_select_high_pin, input alert_pin_n, attach_detected_pin_n);
	modport client (output sda_c_o, sda_c_oe, input scl, sda,
		input comm_or_limit_strap_pin, fault_latch_select_pin, attach_detect_select_pin,
		port_power_enable_pin, emulation_enable_pin, profile_select_low_pin,
		profile_select_high_pin, output alert_pin_n, attach_detected_pin_n);
endinterface
`default_nettype wire

// *** hw/pcs_client.sv ***
// client end: two-wire register client with auto-increment pointer and stand-alone mode
`timescale 1ns/1ps
`default_nettype none
module pcs_client #(
	parameter logic [6:0] client_addr = pcs_pkg::client_addr_def,
	parameter int unsigned reg_depth = 256
) (
	input wire logic clk_sys,
	input wire logic nrst,
	pcs_link_if.client link,
	input wire logic fault_event,
	input wire logic attach_event,
	output logic standalone_mode,
	output logic fault_active,
	output logic attach_enable,
	output logic [7:0] pointer
);
	import pcs_pkg::*;
	// ==========================================================
	// pin synchronisers
	logic [1:0] scl_s, sda_s, strap_s, latch_s, sel_s, pwr_s;
	logic scl_q, sda_q;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			strap_s <= 2'h0;
			latch_s <= 2'h0;
			sel_s <= 2'h0;
			pwr_s <= 2'h0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_s <= {scl_s[0], link.scl};
			sda_s <= {sda_s[0], link.sda};
			strap_s <= {strap_s[0], link.comm_or_limit_strap_pin};
			latch_s <= {latch_s[0], link.fault_latch_select_pin};
			sel_s <= {sel_s[0], link.attach_detect_select_pin};
			pwr_s <= {pwr_s[0], link.port_power_enable_pin};
			scl_q <= scl_s[1];
			sda_q <= sda_s[1];
		end
	end
	wire scl_rise = scl_s[1] && !scl_q;
	wire scl_fall = !scl_s[1] && scl_q;
	wire start_cond = scl_s[1] && scl_q && sda_q && !sda_s[1];
	wire stop_cond = scl_s[1] && scl_q && !sda_q && sda_s[1];
	// ==========================================================
	// register store
	logic [7:0] mem [reg_depth];
	pcs_client_state_t state_reg;
	logic [7:0] shift_reg, ptr_reg, tx_reg;
	logic [3:0] cnt_reg;
	logic first_reg, rw_reg, drive_low_reg, acked_reg, standalone_reg;
	wire [7:0] rx_byte = {shift_reg[6:0], sda_s[1]};
	wire addr_hit = rx_byte[7:1] == client_addr;
	wire [7:0] ptr_inc = ptr_reg + ptr_wrap_step;
	always_ff @(posedge clk_sys) begin
		if (state_reg == pcs_c_rx && scl_rise && cnt_reg == 4'd7 && !first_reg
			&& !standalone_reg)
			mem[ptr_reg] <= rx_byte;
	end
	// ==========================================================
	// byte engine
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_reg <= pcs_c_idle;
			shift_reg <= 8'h00;
			ptr_reg <= ptr_reset;
			tx_reg <= 8'h00;
			cnt_reg <= 4'h0;
			first_reg <= 1'b0;
			rw_reg <= 1'b0;
			drive_low_reg <= 1'b0;
			acked_reg <= 1'b0;
		end else if (stop_cond || standalone_reg) begin
			state_reg <= pcs_c_idle;
			drive_low_reg <= 1'b0;
		end else if (start_cond) begin
			state_reg <= pcs_c_addr; // repeated start too
			cnt_reg <= 4'h0;
			drive_low_reg <= 1'b0;
		end else begin
			case (state_reg)
				pcs_c_idle: begin
					drive_low_reg <= 1'b0;
				end
				pcs_c_addr, pcs_c_rx: begin
					if (scl_rise) begin
						shift_reg <= rx_byte;
						cnt_reg <= cnt_reg + 4'd1;
						if (cnt_reg == 4'd7) begin
							if (state_reg == pcs_c_addr) begin
								rw_reg <= rx_byte[0];
								first_reg <= 1'b1;
								acked_reg <= addr_hit;
							end else begin
								acked_reg <= 1'b1;
								if (first_reg)
									ptr_reg <= rx_byte;
								else
									ptr_reg <= ptr_inc;
								first_reg <= 1'b0;
							end
						end
					end
					if (scl_fall && cnt_reg == 4'd8) begin
						state_reg <= acked_reg ? pcs_c_ack : pcs_c_idle;
						drive_low_reg <= acked_reg;
					end
				end
				pcs_c_ack: begin
					if (scl_fall) begin
						cnt_reg <= 4'h0;
						if (rw_reg) begin
							state_reg <= pcs_c_tx;
							tx_reg <= {mem[ptr_reg][6:0], 1'b0};
							drive_low_reg <= !mem[ptr_reg][7];
							ptr_reg <= ptr_inc;
						end else begin
							state_reg <= pcs_c_rx;
							drive_low_reg <= 1'b0;
						end
					end
				end
				pcs_c_tx: begin
					if (scl_fall) begin
						cnt_reg <= cnt_reg + 4'd1;
						if (cnt_reg == 4'd7) begin
							drive_low_reg <= 1'b0; // release for host ack
						end else if (cnt_reg == 4'd8) begin
							state_reg <= pcs_c_idle;
						end else begin
							drive_low_reg <= !tx_reg[7];
							tx_reg <= {tx_reg[6:0], 1'b0};
						end
					end
					if (scl_rise && cnt_reg == 4'd8) begin
						if (sda_s[1])
							state_reg <= pcs_c_idle; // host nack ends read
						else
							state_reg <= pcs_c_ack; // next byte
					end
				end
				default: state_reg <= pcs_c_idle;
			endcase
		end
	end
	// ==========================================================
	// stand-alone fault and attach handling
	logic fault_reg, pwr_prev_reg, attach_reg;
	wire latch_mode = standalone_reg && latch_s[1];
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			standalone_reg <= 1'b0;
			fault_reg <= 1'b0;
			pwr_prev_reg <= 1'b0;
			attach_reg <= 1'b0;
		end else begin
			standalone_reg <= strap_s[1];
			pwr_prev_reg <= pwr_s[1];
			if (fault_event)
				fault_reg <= 1'b1;
			else if (!latch_mode)
				fault_reg <= 1'b0;
			else if (pwr_s[1] != pwr_prev_reg)
				fault_reg <= 1'b0;
			attach_reg <= attach_enable && attach_event;
		end
	end
	assign attach_enable = standalone_reg && sel_s[1];
	assign standalone_mode = standalone_reg;
	assign fault_active = fault_reg;
	assign pointer = ptr_reg;
	assign link.sda_c_o = 1'b0;
	assign link.sda_c_oe = drive_low_reg;
	assign link.alert_pin_n = !fault_reg;
	assign link.attach_detected_pin_n = !attach_reg;
endmodule // pcs_client
`default_nettype wire

// *** dv/pcs_link_chk.sv ***
// concurrent checks on the two-wire link and the stand-alone pins
`timescale 1ns/1ps
`default_nettype none
module pcs_link_chk #(
	parameter logic [6:0] client_addr = pcs_pkg::client_addr_def
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_c_o,
	input wire logic sda_c_oe,
	input wire logic comm_or_limit_strap_pin,
	input wire logic fault_latch_select_pin,
	input wire logic attach_detect_select_pin,
	input wire logic port_power_enable_pin,
	input wire logic alert_pin_n,
	input wire logic attach_detected_pin_n
);
	import pcs_pkg::*;
	// ==========================================
	// bus tracking
	logic scl_reg, sda_reg, foreign_reg;
	logic [3:0] cnt_reg;
	logic [7:0] shift_reg;
	wire logic pull = sda_c_oe && !sda_c_o;
	wire logic rise = scl && !scl_reg;
	wire logic start = scl && scl_reg && sda_reg && !sda;
	wire logic hit = shift_reg[7:1] == client_addr;
	wire logic solo = comm_or_limit_strap_pin;
	// count saturates so only the first byte after a start is judged
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			cnt_reg <= 4'hf;
			shift_reg <= 8'h00;
			foreign_reg <= 1'b0;
		end else begin
			scl_reg <= scl;
			sda_reg <= sda;
			if (start) cnt_reg <= 4'h0;
			else if (rise && cnt_reg != 4'hf) cnt_reg <= cnt_reg + 4'h1;
			if (rise) shift_reg <= {shift_reg[6:0], sda};
			if (start) foreign_reg <= 1'b0;
			else if (rise && cnt_reg == 4'h8 && !hit) foreign_reg <= 1'b1;
		end
	end
	// ==========================================
	// assertions
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	a_addr_ack_match: assert property (
		rise && cnt_reg == 4'h8 && !solo |-> pull == hit)
		else $error("address ack does not match");
	a_foreign_silent: assert property (
		foreign_reg |-> !pull)
		else $error("client drives data after foreign address");
	a_pull_scl_low: assert property (
		$rose(pull) |-> !scl)
		else $error("client pulled data while clock high");
	a_release_scl_low: assert property (
		$fell(pull) |-> !scl)
		else $error("client released data while clock high");
	a_solo_quiet: assert property (
		solo && $past(comm_or_limit_strap_pin, 4) |-> !pull)
		else $error("client drives link in stand-alone mode");
	a_attach_one: assert property (
		$fell(attach_detected_pin_n) |=> attach_detected_pin_n)
		else $error("attach pulse longer than one cycle");
	a_attach_off: assert property (
		solo && !attach_detect_select_pin && $past(comm_or_limit_strap_pin, 4) &&
		!$past(attach_detect_select_pin, 4) |-> attach_detected_pin_n)
		else $error("attach reported while detection off");
	a_latch_holds: assert property (
		solo && fault_latch_select_pin && $past(comm_or_limit_strap_pin, 6) &&
		$past(fault_latch_select_pin, 6) && !alert_pin_n &&
		port_power_enable_pin == $past(port_power_enable_pin, 6) |=> !alert_pin_n)
		else $error("latched fault cleared without enable change");
endmodule // pcs_link_chk
`default_nettype wire

// *** dv/port_ctrl_serial_client_standalone_tb.sv ***
// bench: host and client joined over the link, driven through host registers
`timescale 1ns/1ps
`default_nettype none
module port_ctrl_serial_client_standalone_tb;
	import pcs_pkg::*;
	logic clk_sys, nrst, fault_event, attach_event, irq, standalone_mode;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] pointer;
	int n_mismatch = 0;
	int comparisons = 0;
	pcs_link_if link ();
	pcs_host i_pcs_host (.clk_sys, .nrst, .link(link.host), .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
	pcs_client i_pcs_client (.clk_sys, .nrst, .link(link.client), .fault_event, .attach_event,
		.standalone_mode, .fault_active(), .attach_enable(), .pointer);
	pcs_link_chk i_pcs_link_chk (.clk_sys, .nrst, .scl(link.scl), .sda(link.sda),
		.sda_c_o(link.sda_c_o), .sda_c_oe(link.sda_c_oe),
		.comm_or_limit_strap_pin(link.comm_or_limit_strap_pin),
		.fault_latch_select_pin(link.fault_latch_select_pin),
		.attach_detect_select_pin(link.attach_detect_select_pin),
		.port_power_enable_pin(link.port_power_enable_pin), .alert_pin_n(link.alert_pin_n),
		.attach_detected_pin_n(link.attach_detected_pin_n));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// ==========================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// each bus task opens on an edge so no signal is assigned twice in one step
	task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// one link step; completion is taken from the interrupt, which the status read clears
	task automatic link_op(input logic [4:0] c, input logic [7:0] w, output logic [7:0] rd,
		output logic nack);
		logic [31:0] v;
		logic [1:0] r;
		axi_wr(reg_wdata, {24'h0, w}, r);
		axi_wr(reg_ctrl, {27'h0, c}, r);
		do @(posedge clk_sys); while (irq !== 1'b1);
		axi_rd(reg_status, v, r);
		chk(v[0], 1'b1);
		nack = v[1];
		axi_rd(reg_rdata, v, r);
		rd = v[7:0];
		chk(irq, 1'b0);
	endtask
	task automatic pulse(input logic f, input logic a, output int low_a, output int low_f);
		repeat (8) @(posedge clk_sys);
		fault_event <= f;
		attach_event <= a;
		low_a = 0;
		low_f = 0;
		repeat (20) begin
			@(posedge clk_sys);
			if (link.attach_detected_pin_n === 1'b0) low_a++;
			if (link.alert_pin_n === 1'b0) low_f++;
			fault_event <= 1'b0;
			attach_event <= 1'b0;
		end
	endtask
	// ==========================================
	// scenarios
	task automatic t_block_write();
		logic [7:0] d;
		logic nk;
		link_op(5'h05, {client_addr_def, 1'b0}, d, nk);
		chk(nk, 1'b0);
		link_op(5'h04, 8'hfe, d, nk);
		chk(pointer, 8'hfe);
		for (int i = 0; i < 4; i++) begin
			link_op(i == 3 ? 5'h06 : 5'h04, 8'ha1 + 8'(i), d, nk);
			chk(nk, 1'b0);
		end
		chk(pointer, 8'h02);
	endtask
	task automatic t_block_read();
		logic [7:0] d;
		logic nk;
		link_op(5'h05, {client_addr_def, 1'b0}, d, nk);
		link_op(5'h04, 8'hfe, d, nk);
		link_op(5'h05, {client_addr_def, 1'b1}, d, nk);
		chk(nk, 1'b0);
		for (int i = 0; i < 3; i++) begin
			link_op(i == 2 ? 5'h1a : 5'h08, 8'h00, d, nk);
			chk(d, 8'ha1 + 8'(i));
		end
		chk(pointer, 8'h01);
	endtask
	task automatic t_receive();
		logic [7:0] d;
		logic nk;
		link_op(5'h05, {client_addr_def, 1'b1}, d, nk);
		chk(nk, 1'b0);
		link_op(5'h1a, 8'h00, d, nk);
		chk(d, 8'ha4);
		chk(pointer, 8'h02);
	endtask
	task automatic t_regs();
		logic [31:0] v;
		logic [1:0] r;
		axi_rd(6'h18, v, r);
		chk(r, 2'h2);
		axi_wr(6'h3c, 32'h1, r);
		chk(r, 2'h2);
		axi_wr(reg_mask, 32'h0, r);
		axi_wr(reg_wdata, 32'ha0, r);
		axi_wr(reg_ctrl, 32'h7, r);
		do axi_rd(reg_ctrl, v, r); while (v[5] !== 1'b0);
		chk(irq, 1'b0);
		axi_rd(reg_status, v, r);
		chk(v[1:0], 2'h3);
		axi_rd(reg_status, v, r);
		chk(v[1:0], 2'h0);
		axi_wr(reg_mask, 32'h3, r);
	endtask
	task automatic t_solo();
		logic [1:0] r;
		logic [7:0] d;
		logic nk;
		int la, lf;
		axi_wr(reg_strap, 32'h5, r);
		pulse(1'b0, 1'b1, la, lf);
		chk(standalone_mode, 1'b1);
		chk(la, 1);
		axi_wr(reg_strap, 32'h1, r);
		pulse(1'b0, 1'b1, la, lf);
		chk(la, 0);
		pulse(1'b1, 1'b0, la, lf);
		chk(lf != 0 && link.alert_pin_n === 1'b1, 1);
		axi_wr(reg_strap, 32'h3, r);
		pulse(1'b1, 1'b0, la, lf);
		chk(link.alert_pin_n, 1'b0);
		axi_wr(reg_strap, 32'hb, r);
		pulse(1'b0, 1'b0, la, lf);
		chk(link.alert_pin_n, 1'b1);
		link_op(5'h07, {client_addr_def, 1'b0}, d, nk);
		chk(nk, 1'b1);
		axi_wr(reg_strap, 32'h0, r);
	endtask
	// ==========================================
	// main sequence and watchdog
	initial begin
		logic [1:0] r;
		nrst = 1'b0;
		fault_event = 1'b0;
		attach_event = 1'b0;
		s_axi_awaddr = 6'h00;
		s_axi_araddr = 6'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		axi_wr(reg_mask, 32'h3, r);
		t_block_write();
		t_block_read();
		t_receive();
		t_regs();
		t_solo();
		finish_test();
	end
	initial begin
		repeat (100000) @(posedge clk_sys);
		n_mismatch++;
		finish_test();
	end
endmodule // port_ctrl_serial_client_standalone_tb
`default_nettype wire
